/* File: csc_defines.svh */
/*
 * Constants of the charge state controller: register offsets, field
 * positions, reset values and timing figures.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

// Register byte offsets
`define CSC_REG_CTRL 8'h00
`define CSC_REG_PRE_LIM 8'h04
`define CSC_REG_FAST_LIM 8'h08
`define CSC_REG_STATUS 8'h0C

// Control register fields and reset value
`define CSC_CTRL_BLINK_BIT 0
`define CSC_CTRL_SYS_BIT 1
`define CSC_CTRL_RST 2'h0

// Safety timer limits in seconds, plain defaults
`define CSC_PRE_LIM_S 16'h0708
`define CSC_FAST_LIM_S 16'h4650

// Status register fields
`define CSC_ST_STATE_LSB 0
`define CSC_ST_TFLT_BIT 4
`define CSC_ST_OVP_BIT 5
`define CSC_ST_ABOVE_BIT 6
`define CSC_ST_TMR_LSB 16

// Blink half period (toggle every second) and clock rate
`define CSC_BLINK_HALF_MS 1000
`define CSC_CLK_KHZ 100000

// Current selection codes
`define CSC_CUR_OFF 2'h0
`define CSC_CUR_PRE 2'h1
`define CSC_CUR_FAST 2'h2
`define CSC_CUR_DETECT 2'h3

`endif

/* File: csc_pkg.sv */
/*
 * Types shared by the charge state controller: states, sensed flags
 * and power stage drive.
 * Assumes csc_defines.svh supplies the numeric constants.
 */
package csc_pkg;

   // Gray codes along sleep, precharge, fast, regulation, done
   typedef enum logic [3:0] {
      CSC_SLEEP = 4'h0,
      CSC_PRECHG = 4'h1,
      CSC_FASTCHG = 4'h3,
      CSC_VREG = 4'h2,
      CSC_DONE = 4'h6,
      CSC_INHIBIT = 4'h7,
      CSC_SUSPEND = 4'h5,
      CSC_FAULT = 4'h4,
      CSC_OVP = 4'hC,
      CSC_ABSENT = 4'hD
   } csc_state_type;

   // Comparator results from the analog front end, all active high
   typedef struct packed {
      logic sleep_exit;      // Supply above sleep_exit_threshold
      logic below_recharge;  // Battery below recharge_threshold
      logic at_regulation;   // Battery at regulation_voltage
      logic term_current;    // Current at or below termination level
      logic over_voltage;    // Output overvoltage
      logic below_lowv;      // Battery below low_voltage_threshold
      logic over_discharge;  // Battery below over_discharge_threshold
      logic temp_ok;         // temp_sense_in and die temperature in range
   } csc_sense_type;

   // Commands to the power stage
   typedef struct packed {
      logic pwm_en;
      logic [1:0] current_sel;
      logic two_cell;
   } csc_drive_type;

endpackage

/* File: csc_charge_ctrl.sv */
/*
 * Charge state controller: sequences precharge, fast charge, voltage
 * regulation and termination, runs the safety timer, recovers from
 * timer and overvoltage faults, drives status and power-good pull-downs,
 * and offers an APB register slave.
 * Assumes all inputs are synchronous to clock_in (comparator flags are
 * already synchronised upstream) and a standard APB master.
 */
`include "csc_defines.svh"

module csc_charge_ctrl #(
   parameter int unsigned SEC_CYCLES = `CSC_BLINK_HALF_MS * `CSC_CLK_KHZ,
   parameter logic [15:0] PRE_LIM_DEF = `CSC_PRE_LIM_S,
   parameter logic [15:0] FAST_LIM_DEF = `CSC_FAST_LIM_S
) (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire csc_pkg::csc_sense_type sense_in,
   input wire logic charge_en_n_in,
   input wire logic cells_sel_in,
   input wire logic ttc_low_in,
   input wire logic ttc_high_in,
   input wire logic rate_select_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output csc_pkg::csc_drive_type drive_out,
   output logic status_out_a_pd_out,
   output logic status_out_b_pd_out,
   output logic power_good_n_pd_out
);

   csc_pkg::csc_state_type state_r;
   csc_pkg::csc_state_type state_nxt;
   csc_pkg::csc_state_type resume_r;
   csc_pkg::csc_state_type entry_st;
   logic [1:0] ctrl_r;
   logic [15:0] pre_lim_r;
   logic [15:0] fast_lim_r;
   logic [15:0] timer_r;
   logic [31:0] div_r;
   logic tick;
   logic blink_r;
   logic ce_n_r;
   logic ttc_low_r;
   logic ce_fall;
   logic ttc_rise;
   logic sys_var;
   logic tmr_en;
   logic term_en;
   logic charging;
   logic timer_clr;
   logic expired;
   logic tflt_r;
   logic seen_above_r;
   logic apb_wr;
   logic apb_setup;

   // Entry state of a fresh charge cycle
   function automatic csc_pkg::csc_state_type charge_entry(
      input csc_pkg::csc_sense_type s,
      input logic sys,
      input logic rate
   );
      csc_pkg::csc_state_type st;
      st = csc_pkg::CSC_FASTCHG;
      if (s.at_regulation) begin
         st = csc_pkg::CSC_VREG;
      end else if (sys) begin
         st = rate ? csc_pkg::CSC_FASTCHG : csc_pkg::CSC_PRECHG;
      end else if (s.below_lowv) begin
         st = csc_pkg::CSC_PRECHG;
      end
      return st;
   endfunction

   // Is the state one in which current flows to the battery
   function automatic logic is_charging(input csc_pkg::csc_state_type s);
      return (s == csc_pkg::CSC_PRECHG) || (s == csc_pkg::CSC_FASTCHG) ||
             (s == csc_pkg::CSC_VREG);
   endfunction

   assign sys_var = ctrl_r[`CSC_CTRL_SYS_BIT];
   assign entry_st = charge_entry(sense_in, sys_var, rate_select_in);
   assign charging = is_charging(state_r);
   assign ce_fall = ce_n_r && !charge_en_n_in;
   assign ttc_rise = ttc_low_r && !ttc_low_in;
   // System variant never times or terminates
   assign tmr_en = !sys_var && !ttc_low_in && !ttc_high_in;
   assign term_en = !sys_var && !ttc_low_in;
   assign tick = (div_r == SEC_CYCLES - 1);
   assign expired = tmr_en && ((state_r == csc_pkg::CSC_PRECHG) ? (timer_r >= pre_lim_r)
                                                                : (timer_r >= fast_lim_r));

   // Pin history for edge detection
   // Seeded from the pin during reset, so no false enable edge follows release
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ce_n_r <= charge_en_n_in;
         ttc_low_r <= 1'b0;
      end else begin
         ce_n_r <= charge_en_n_in;
         ttc_low_r <= ttc_low_in;
      end
   end

   // One-second divider; also paces the safety timer
   // One shared divider keeps blink phase and timer seconds in step
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || tick) begin
         div_r <= 32'h0000_0000;
      end else begin
         div_r <= div_r + 32'h0000_0001;
      end
   end

   // Blink phase flips each second for a 0.5 Hz flash
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         blink_r <= 1'b0;
      end else if (tick) begin
         blink_r <= !blink_r;
      end
   end

   // Next state; supply loss and enable level outrank everything
   // Comparator flags are used directly, already synchronous to this clock
   always_comb begin
      state_nxt = state_r;
      if (!sense_in.sleep_exit) begin
         state_nxt = csc_pkg::CSC_SLEEP;
      end else if (charge_en_n_in) begin
         state_nxt = csc_pkg::CSC_INHIBIT;
      end else if (sense_in.over_voltage) begin
         // Honoured straight out of sleep too, so a charge never starts into overvoltage
         state_nxt = csc_pkg::CSC_OVP;
      end else if (ce_fall) begin
         state_nxt = entry_st;
      end else if (ttc_rise && state_r != csc_pkg::CSC_OVP) begin
         state_nxt = entry_st;
      end else begin
         unique case (state_r)
            csc_pkg::CSC_SLEEP, csc_pkg::CSC_INHIBIT: begin
               // Start only if the battery wants charge
               state_nxt = sense_in.below_recharge ? entry_st : csc_pkg::CSC_DONE;
            end
            csc_pkg::CSC_PRECHG, csc_pkg::CSC_FASTCHG, csc_pkg::CSC_VREG: begin
               if (!sense_in.temp_ok) begin
                  state_nxt = csc_pkg::CSC_SUSPEND;
               end else if (expired) begin
                  state_nxt = csc_pkg::CSC_FAULT;
               end else if (sense_in.at_regulation) begin
                  if (state_r != csc_pkg::CSC_VREG) begin
                     state_nxt = csc_pkg::CSC_VREG;
                  end else if (term_en && sense_in.term_current) begin
                     state_nxt = csc_pkg::CSC_DONE;
                  end
               end else if (state_r == csc_pkg::CSC_VREG && term_en && sense_in.term_current) begin
                  state_nxt = csc_pkg::CSC_DONE;
               end else if (sys_var && state_r != csc_pkg::CSC_VREG) begin
                  state_nxt = rate_select_in ? csc_pkg::CSC_FASTCHG : csc_pkg::CSC_PRECHG;
               end else if (state_r == csc_pkg::CSC_PRECHG && !sense_in.below_lowv) begin
                  state_nxt = csc_pkg::CSC_FASTCHG;
               end
            end
            csc_pkg::CSC_DONE: begin
               if (sense_in.below_recharge) begin
                  state_nxt = entry_st;
               end
            end
            csc_pkg::CSC_SUSPEND: begin
               if (sense_in.temp_ok) begin
                  state_nxt = resume_r;
               end
            end
            csc_pkg::CSC_FAULT: begin
               // Cleared by the supply, enable and timer pin checks above, or here once the battery has been seen above and falls again
               if (seen_above_r && sense_in.below_recharge) begin
                  state_nxt = csc_pkg::CSC_ABSENT;
               end
            end
            csc_pkg::CSC_OVP: begin
               if (sense_in.below_recharge) begin
                  state_nxt = entry_st;
               end
            end
            csc_pkg::CSC_ABSENT: begin
               // Detect pulse lasts until the next second boundary
               if (tick) begin
                  state_nxt = entry_st;
               end
            end
            default: begin
               state_nxt = csc_pkg::CSC_SLEEP;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state_r <= csc_pkg::CSC_SLEEP;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Remember where a temperature suspend interrupted charging
   // Precharge default is the gentlest rate if a resume ever finds no record
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         resume_r <= csc_pkg::CSC_PRECHG;
      end else if (charging && state_nxt == csc_pkg::CSC_SUSPEND) begin
         resume_r <= state_r;
      end
   end

   // Timer zeroes on entry to precharge or fast charge, never on a return from suspend
   assign timer_clr = ce_fall || ttc_rise || !tmr_en ||
                      (state_nxt != state_r && state_r != csc_pkg::CSC_SUSPEND &&
                       (state_nxt == csc_pkg::CSC_PRECHG || state_nxt == csc_pkg::CSC_FASTCHG));

   // Safety timer in seconds; frozen while suspended
   // Saturates instead of wrapping, so an expired count can never roll back
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || timer_clr) begin
         timer_r <= 16'h0000;
      end else if (tick && charging && timer_r != 16'hFFFF) begin
         timer_r <= timer_r + 16'h0001;
      end
   end

   // Latched timer fault and the above-recharge sighting
   // Set and clear never meet: an enable fall leads to sleep, overvoltage or a fresh charge state, never to fault
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || ce_fall) begin
         tflt_r <= 1'b0;
         seen_above_r <= 1'b0;
      end else if (state_r != csc_pkg::CSC_FAULT && state_nxt == csc_pkg::CSC_FAULT) begin
         tflt_r <= 1'b1;
         seen_above_r <= !sense_in.below_recharge;
      end else if (state_r == csc_pkg::CSC_FAULT) begin
         tflt_r <= (state_nxt == csc_pkg::CSC_FAULT);
         if (!sense_in.below_recharge) begin
            seen_above_r <= 1'b1;
         end
      end
   end

   // Power stage drive; PWM off outside active charging, detect current in absent, and in fault while below recharge and never seen above
   // Decoded from the next state so the power stage stops at the same edge as the state
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         drive_out <= '0;
      end else begin
         drive_out.two_cell <= cells_sel_in;
         drive_out.pwm_en <= is_charging(state_nxt);
         unique case (state_nxt)
            csc_pkg::CSC_PRECHG: drive_out.current_sel <= `CSC_CUR_PRE;
            csc_pkg::CSC_FASTCHG, csc_pkg::CSC_VREG: drive_out.current_sel <= `CSC_CUR_FAST;
            csc_pkg::CSC_ABSENT: drive_out.current_sel <= `CSC_CUR_DETECT;
            csc_pkg::CSC_FAULT: begin
               // Detect current only while still below and never seen above
               drive_out.current_sel <= (sense_in.below_recharge && !seen_above_r)
                                        ? `CSC_CUR_DETECT : `CSC_CUR_OFF;
            end
            default: drive_out.current_sel <= `CSC_CUR_OFF;
         endcase
      end
   end

   // Status pull-downs; a blink variant flashes A in fault, in suspend and while charging an over-discharged battery
   // Status A and B follow the state register, one edge behind the drive; power good follows the supply flag; indicators need no more
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         status_out_a_pd_out <= 1'b0;
         status_out_b_pd_out <= 1'b0;
         power_good_n_pd_out <= 1'b0;
      end else begin
         power_good_n_pd_out <= sense_in.sleep_exit;
         status_out_b_pd_out <= (state_r == csc_pkg::CSC_DONE);
         if (ctrl_r[`CSC_CTRL_BLINK_BIT] &&
             (state_r == csc_pkg::CSC_FAULT || state_r == csc_pkg::CSC_SUSPEND ||
              (charging && sense_in.over_discharge))) begin
            status_out_a_pd_out <= blink_r;
         end else begin
            status_out_a_pd_out <= charging;
         end
      end
   end

   // APB: answer in the first access cycle, no wait states
   // Limitation: no wait states, so every register must be readable in a single cycle
   assign apb_setup = psel_in && !penable_in;
   assign apb_wr = psel_in && penable_in && pready_out && pwrite_in;

   // Writable control and timer limits
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ctrl_r <= `CSC_CTRL_RST;
         pre_lim_r <= PRE_LIM_DEF;
         fast_lim_r <= FAST_LIM_DEF;
      end else if (apb_wr) begin
         unique case (paddr_in)
            `CSC_REG_CTRL: ctrl_r <= pwdata_in[1:0];
            `CSC_REG_PRE_LIM: pre_lim_r <= pwdata_in[15:0];
            `CSC_REG_FAST_LIM: fast_lim_r <= pwdata_in[15:0];
            default: ;
         endcase
      end
   end

   // Read data and completion prepared during the setup cycle
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end else begin
         pready_out <= apb_setup;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         if (apb_setup) begin
            unique case (paddr_in)
               `CSC_REG_CTRL: prdata_out <= {30'h0, ctrl_r};
               `CSC_REG_PRE_LIM: prdata_out <= {16'h0000, pre_lim_r};
               `CSC_REG_FAST_LIM: prdata_out <= {16'h0000, fast_lim_r};
               `CSC_REG_STATUS: begin
                  prdata_out[`CSC_ST_STATE_LSB +: 4] <= state_r;
                  prdata_out[`CSC_ST_TFLT_BIT] <= tflt_r;
                  prdata_out[`CSC_ST_OVP_BIT] <= (state_r == csc_pkg::CSC_OVP);
                  prdata_out[`CSC_ST_ABOVE_BIT] <= seen_above_r;
                  prdata_out[`CSC_ST_TMR_LSB +: 16] <= timer_r;
               end
               default: pslverr_out <= 1'b1; // Unmapped address
            endcase
         end
      end
   end

endmodule

/* File: csc_charge_ctrl_monitor.sv */
/*
 * Port-level assertions for the charge state controller.
 * Assumes one clock domain and a bind onto csc_charge_ctrl.
 */
module csc_charge_ctrl_monitor (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire csc_pkg::csc_sense_type sense_in,
   input wire logic charge_en_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire csc_pkg::csc_drive_type drive_out,
   input wire logic status_out_a_pd_out,
   input wire logic status_out_b_pd_out,
   input wire logic power_good_n_pd_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   // Bus setup and its one-cycle answer
   sequence apb_setup;
      psel_in && !penable_in;
   endsequence
   sequence apb_answer;
      pready_out ##1 !pready_out;
   endsequence

   // Supply and enable drive the pins one edge later, status two
   chk_apb_ready: assert property (apb_setup |=> apb_answer) else $error("bus answer missing");
   chk_apb_idle: assert property (!psel_in |=> !pready_out) else $error("answer without request");
   chk_apb_unmapped: assert property (psel_in && !penable_in && paddr_in > 8'h0C |=> pslverr_out && prdata_out == 32'h0)
      else $error("unmapped access not refused");
   chk_sleep_pg: assert property (!sense_in.sleep_exit |=> !power_good_n_pd_out && !drive_out.pwm_en)
      else $error("sleep not entered");
   chk_pg_on: assert property (sense_in.sleep_exit |=> power_good_n_pd_out)
      else $error("power good missing");
   chk_inhibit_off: assert property (sense_in.sleep_exit && charge_en_n_in |=> !drive_out.pwm_en ##1 !status_out_a_pd_out)
      else $error("charging while inhibited");
   chk_ovp_stop: assert property (sense_in.sleep_exit && !charge_en_n_in && sense_in.over_voltage
      |=> !drive_out.pwm_en ##1 (!status_out_a_pd_out && !status_out_b_pd_out))
      else $error("overvoltage not stopped");
   chk_status_excl: assert property (!(status_out_a_pd_out && status_out_b_pd_out))
      else $error("both status pins on");
endmodule

bind csc_charge_ctrl csc_charge_ctrl_monitor mon_u (.clock_in, .sys_rst_in, .sense_in, .charge_en_n_in, .psel_in,
   .penable_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out, .drive_out, .status_out_a_pd_out,
   .status_out_b_pd_out, .power_good_n_pd_out);

/* File: csc_host_model.sv */
/*
 * Host and indicator side: pull-ups on the status pins, host-driven
 * charge enable and rate select.
 * Assumes requests change right after a rising clock edge.
 */
module csc_host_model (
   input wire logic clock_in,
   input wire logic en_req_in,
   input wire logic fast_req_in,
   input wire logic status_a_pd_in,
   input wire logic status_b_pd_in,
   input wire logic pg_pd_in,
   output logic charge_en_n_out = 1'h1,
   output logic rate_select_out = 1'h0,
   output logic status_a_level_out,
   output logic status_b_level_out,
   output logic power_good_level_out
);
   // Host changes its pins only after an edge, never mid-cycle
   always @(posedge clock_in) begin
      charge_en_n_out <= ~en_req_in;
      rate_select_out <= fast_req_in;
   end

   // Pull-ups: an enabled pull-down reads low
   assign status_a_level_out = ~status_a_pd_in;
   assign status_b_level_out = ~status_b_pd_in;
   assign power_good_level_out = ~pg_pd_in;
endmodule

/* File: csc_charge_ctrl_test.sv */
/*
 * Self-checking bench for the charge state controller.
 * Assumes short timer parameters: one second is ten clock cycles.
 */
`include "csc_defines.svh"

module csc_charge_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   // Low byte: enable, cells, pwm, current[1:0], check current, A on, B on
   typedef struct packed {
      logic [7:0] sense;
      logic en;
      logic cells;
      logic pwm;
      logic [1:0] cur;
      logic cc;
      logic a;
      logic b;
   } csc_row_type;
   logic clock_in, sys_rst_in, cells_sel_in, ttc_low_in, ttc_high_in, en_req, fast_req, ce_n, rate;
   logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err, sa_pd, sb_pd, pg_pd, sa_lvl, sb_lvl, pg_lvl, prev;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   csc_pkg::csc_sense_type sense_in;
   csc_pkg::csc_drive_type drive_out;
   int mismatches, checked, i, n;
   csc_row_type rows [6];

   csc_charge_ctrl #(.SEC_CYCLES(10), .PRE_LIM_DEF(16'h0003), .FAST_LIM_DEF(16'h0005)) dut_u (.clock_in,
      .sys_rst_in, .sense_in, .charge_en_n_in(ce_n), .cells_sel_in, .ttc_low_in, .ttc_high_in,
      .rate_select_in(rate), .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
      .pslverr_out, .drive_out, .status_out_a_pd_out(sa_pd), .status_out_b_pd_out(sb_pd), .power_good_n_pd_out(pg_pd));
   csc_host_model host_u (.clock_in, .en_req_in(en_req), .fast_req_in(fast_req), .status_a_pd_in(sa_pd),
      .status_b_pd_in(sb_pd), .pg_pd_in(pg_pd), .charge_en_n_out(ce_n), .rate_select_out(rate),
      .status_a_level_out(sa_lvl), .status_b_level_out(sb_lvl), .power_good_level_out(pg_lvl));

   // Clock at 100 MHz
   initial begin
      clock_in = 1'h0;
      forever #5 clock_in = ~clock_in;
   end

   task print_verdict;
      if (mismatches == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'h1) begin
         mismatches++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask

   // Apply comparator flags, then let the given cycles pass
   task put(input logic [7:0] s, input int c);
      sense_in <= s;
      repeat (c) @(posedge clock_in);
   endtask

   // One bus transfer; bounded wait, since a lost answer would hang
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      int k;
      @(posedge clock_in);
      psel_in <= 1'h1;
      penable_in <= 1'h0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1'h1;
      k = 0;
      do begin
         @(posedge clock_in);
         k++;
      end while (pready_out !== 1'h1 && k < 20);
      if (k >= 20) begin
         chk(1'h0, "bus timeout");
         print_verdict();
      end
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
   endtask

   initial begin
      rows = '{16'h0084, 16'h8104, 16'hC5AE, 16'hC1F6, 16'hA1E2, 16'hB185};
      sys_rst_in = 1'h1;
      sense_in = '0;
      en_req = 1'h1;
      fast_req = 1'h0;
      cells_sel_in = 1'h0;
      ttc_low_in = 1'h0;
      ttc_high_in = 1'h0;
      psel_in = 1'h0;
      penable_in = 1'h0;
      pwrite_in = 1'h0;
      paddr_in = 8'h00;
      pwdata_in = 32'h0;
      mismatches = 0;
      checked = 0;
      repeat (10) @(posedge clock_in);
      sys_rst_in <= 1'h0;
      // Register reset values, read-only status and an unmapped word
      apb(1'h0, 8'h00, 32'h0, rd, err);
      chk(rd === 32'h0 && err === 1'h0, "control reset");
      apb(1'h0, 8'h04, 32'h0, rd, err);
      chk(rd === 32'h3, "precharge limit reset");
      apb(1'h1, 8'h04, 32'hFFFF_0004, rd, err);
      apb(1'h0, 8'h04, 32'h0, rd, err);
      chk(rd === 32'h4 && err === 1'h0, "limit write keeps 16 bits");
      apb(1'h1, 8'h0C, 32'hF, rd, err);
      apb(1'h0, 8'h0C, 32'h0, rd, err);
      chk(rd[3:0] === csc_pkg::CSC_SLEEP, "status written");
      apb(1'h0, 8'h10, 32'h0, rd, err);
      chk(err === 1'h1 && rd === 32'h0, "unmapped");
      // Ordinary charge cycle: sleep, inhibit, precharge, fast, regulate, done
      for (i = 0; i < 6; i++) begin
         sense_in <= rows[i].sense;
         en_req <= rows[i].en;
         cells_sel_in <= rows[i].cells;
         repeat (5) @(posedge clock_in);
         chk(drive_out.pwm_en === rows[i].pwm, "pwm");
         chk(!rows[i].cc || drive_out.current_sel === rows[i].cur, "current");
         chk(!rows[i].pwm || drive_out.two_cell === rows[i].cells, "cells");
         chk(sa_lvl === ~rows[i].a && sb_lvl === ~rows[i].b, "status pins");
         chk(pg_lvl === ~rows[i].sense[7], "power good");
      end
      put(8'hC1, 5);
      chk(sa_lvl === 1'h0 && drive_out.pwm_en === 1'h1, "recharge");
      put(8'h89, 5);
      chk(drive_out.pwm_en === 1'h0 && sa_lvl === 1'h1 && sb_lvl === 1'h1, "overvoltage");
      put(8'hC1, 5);
      chk(drive_out.pwm_en === 1'h1, "overvoltage clear");
      put(8'hC0, 5);
      chk(drive_out.pwm_en === 1'h0 && sa_lvl === 1'h1, "suspend");
      // Timer pin: tied high, then low, then rising
      ttc_high_in <= 1'h1;
      put(8'hC1, 80);
      chk(drive_out.pwm_en === 1'h1, "timer off high");
      ttc_high_in <= 1'h0;
      ttc_low_in <= 1'h1;
      put(8'hC1, 80);
      chk(drive_out.pwm_en === 1'h1, "timer off low");
      ttc_low_in <= 1'h0;
      put(8'hC1, 40);
      chk(drive_out.pwm_en === 1'h1, "timer zeroed");
      put(8'hC1, 30);
      chk(drive_out.current_sel === `CSC_CUR_DETECT && sa_lvl === 1'h1, "timer fault");
      // Blink variant: status A toggles every second
      apb(1'h1, 8'h00, 32'h1, rd, err);
      n = 0;
      prev = sa_lvl;
      repeat (40) begin
         @(posedge clock_in);
         if (sa_lvl !== prev)
            n++;
         prev = sa_lvl;
      end
      chk(n >= 3 && n <= 5, "blink");
      apb(1'h1, 8'h00, 32'h0, rd, err);
      en_req <= 1'h0;
      put(8'hC1, 5);
      en_req <= 1'h1;
      put(8'hC1, 5);
      chk(drive_out.current_sel === `CSC_CUR_FAST, "enable toggle");
      // Second timeout, then recovery once the battery has been above recharge
      put(8'hC1, 70);
      put(8'h81, 5);
      chk(drive_out.current_sel === `CSC_CUR_OFF, "detect off above");
      apb(1'h0, 8'h0C, 32'h0, rd, err);
      chk(rd[3:0] === csc_pkg::CSC_FAULT && rd[4] === 1'h1 && rd[6] === 1'h1, "fault latched");
      put(8'hC1, 2);
      chk(drive_out.current_sel === `CSC_CUR_DETECT, "absent detect");
      put(8'hC1, 12);
      chk(drive_out.current_sel === `CSC_CUR_FAST && drive_out.pwm_en === 1'h1, "new cycle");
      // System-controlled variant
      apb(1'h1, 8'h00, 32'h2, rd, err);
      put(8'hC1, 5);
      chk(drive_out.current_sel === `CSC_CUR_PRE, "rate low");
      fast_req <= 1'h1;
      put(8'hC1, 80);
      chk(drive_out.current_sel === `CSC_CUR_FAST && drive_out.pwm_en === 1'h1, "rate high");
      fast_req <= 1'h0;
      put(8'hB1, 5);
      apb(1'h0, 8'h0C, 32'h0, rd, err);
      chk(rd[3:0] === csc_pkg::CSC_VREG && drive_out.pwm_en === 1'h1, "regulation");
      put(8'h89, 5);
      chk(drive_out.pwm_en === 1'h0 && drive_out.current_sel === `CSC_CUR_OFF, "system ovp");
      print_verdict();
   end
endmodule
